// >>> dgc_pkg.sv
// Package of the DMA core global control block: register map, field layout,
// reset values and the bus request carrier.
// Assumes a single system clock domain and a plain strobe register port.
package dgc_pkg;

   // Channel count of the core
   localparam int unsigned NUM_CH      = 4;
   localparam int unsigned REQ_W       = 31;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned ADDR_W      = 32;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_OPERATING_MODE_SELECT  = 32'h4000_2830;
   localparam logic [ADDR_W-1:0] OFS_MULTI_CHANNEL_LAUNCH   = 32'h4000_2848;
   localparam logic [ADDR_W-1:0] OFS_RECEIVE_REQ_OVERRIDE   = 32'h4000_2850;
   localparam logic [ADDR_W-1:0] OFS_TRANSMIT_REQ_OVERRIDE  = 32'h4000_2854;
   localparam logic [ADDR_W-1:0] OFS_ENGINE_QUIESCENT       = 32'h4000_28d0;
   localparam logic [ADDR_W-1:0] OFS_BUILD_OPTIONS          = 32'h4000_28e0;

   // Field positions
   localparam int unsigned POS_MODE_JOINT                = 0;
   localparam int unsigned POS_QUIESCENT                 = 0;
   localparam int unsigned POS_REQ_LSB                   = 1;
   localparam int unsigned POS_FIXED_MARKER_BIT          = 31;
   localparam int unsigned POS_SECOND_PORT_MULTIPLEXER   = 10;
   localparam int unsigned POS_FIRST_PORT_MULTIPLEXER    = 9;
   localparam int unsigned POS_FUNCTIONAL_GATING_PRESENT = 8;
   localparam int unsigned POS_MATRIX_TWO_OUTPUTS        = 7;
   localparam int unsigned POS_MATRIX_PRESENT            = 6;

   // Reset values
   localparam logic [0:0]        RST_OPERATING_MODE = 1'h0;
   localparam logic [NUM_CH-1:0] RST_LAUNCH         = 4'h0;
   localparam logic [REQ_W-1:0]  RST_REQ_OVERRIDE   = 31'h0000_0000;
   localparam logic [0:0]        RST_QUIESCENT      = 1'h1;
   localparam logic [DATA_W-1:0] RST_BUILD_OPTIONS  = 32'h8000_0001;

   // Build option flags of this implementation
   localparam logic FLAG_FIXED_MARKER      = 1'h1;
   localparam logic FLAG_PORT_MUX          = 1'h0;
   localparam logic FLAG_GATING            = 1'h0;
   localparam logic FLAG_MATRIX_TWO_OUTPUT = 1'h0;
   localparam logic FLAG_MATRIX            = 1'h0;

   // One register port request, all strobes one cycle long
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dgc_bus_req_s;

   // Launch and mode signals handed to the channel engines
   typedef struct packed {
      logic              joint;
      logic [NUM_CH-1:0] launch;
   } dgc_chan_ctl_s;

endpackage : dgc_pkg

// >>> dgc_req_override.sv
// One software-owned request override register driving a request bus.
// Assumes the write enable is already decoded on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dgc_req_override (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic                       wr_en,
   input  wire logic [dgc_pkg::DATA_W-1:0] wdata,
   output var  logic [dgc_pkg::REQ_W-1:0]  req
);
   import dgc_pkg::*;

   typedef struct packed {
      logic [REQ_W-1:0] req;
   } dgc_ovr_state_s;

   dgc_ovr_state_s st;
   dgc_ovr_state_s next_st;

   // Upper bits load the bus, bit 0 is dropped on the floor
   always_comb begin
      next_st = st;
      if (wr_en) begin
         next_st.req = wdata[DATA_W-1:POS_REQ_LSB];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st.req <= RST_REQ_OVERRIDE;
      end else begin
         st <= next_st;
      end
   end

   assign req = st.req;

endmodule : dgc_req_override
`default_nettype wire

// >>> dgc_quiesce_track.sv
// Idle tracker: registers whether every channel has stopped and no bus
// transaction is outstanding. Inputs come from same-clock channel logic.
`timescale 1ns/1ps
`default_nettype none
module dgc_quiesce_track (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic [dgc_pkg::NUM_CH-1:0] ch_active,
   input  wire logic                       bus_outstanding,
   output var  logic                       idle
);
   import dgc_pkg::*;

   typedef struct packed {
      logic idle;
   } dgc_idle_state_s;

   dgc_idle_state_s st;
   dgc_idle_state_s next_st;

   // One cycle of latency; a launch cannot hide because channels report busy
   always_comb begin
      next_st      = st;
      next_st.idle = ~(|ch_active) & ~bus_outstanding;
   end

   // Reset shows idle since nothing can be running yet
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st.idle <= RST_QUIESCENT;
      end else begin
         st <= next_st;
      end
   end

   assign idle = st.idle;

endmodule : dgc_quiesce_track
`default_nettype wire

// >>> dgc_global_ctrl.sv
// Global control and status of the four-channel DMA core: operating mode,
// simultaneous channel launch, direct peripheral request override, idle
// status and the fixed build options word.
// Assumes the channel engines and the bus side sit on sys_clk and report
// their activity on plain same-clock levels; software uses a strobe port.
//
// Contract
// - Mode bit one selects joint, else independent
// - One write launches any channel combination together
// - Start bit n launches channel n, write-only
// - Receive override bits 31:1 drive receive requests
// - Transmit override bits 31:1 drive transmit requests
// - Idle reads one only when fully quiet
// - Idle status read-only, one after reset
// - Build options word fixed, equals reset value
// - Build options bit 31 reads one
// - Port multiplexer bits 10 and 9 read zero
// - Clock gating bit 8 reads zero
// - Dual port bit 7 reads zero
// - Matrix present bit 6 reads zero
// - Exactly four channels, start bits map one-to-one
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dgc_global_ctrl (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   // Register port
   input  wire dgc_pkg::dgc_bus_req_s         bus,
   output var  logic [dgc_pkg::DATA_W-1:0]    rd_data,
   // Channel engine status, same clock
   input  wire logic [dgc_pkg::NUM_CH-1:0]    ch_active,
   input  wire logic                          bus_outstanding,
   // Controls toward the channel engines
   output var  dgc_pkg::dgc_chan_ctl_s        chan_ctl,
   // Peripheral request buses
   output var  logic [dgc_pkg::REQ_W-1:0]     rx_req,
   output var  logic [dgc_pkg::REQ_W-1:0]     tx_req,
   // Idle level for power control outside
   output var  logic                          core_idle
);
   import dgc_pkg::*;

   // Control state held here; the override and idle registers sit in the leaf modules
   typedef struct packed {
      logic              joint;
      logic [NUM_CH-1:0] launch;
      logic [DATA_W-1:0] rd_data;
   } dgc_ctrl_state_s;

   dgc_ctrl_state_s st;
   dgc_ctrl_state_s next_st;

   logic                 rx_wr;
   logic                 tx_wr;
   logic                 idle_q;
   logic [REQ_W-1:0]     rx_q;
   logic [REQ_W-1:0]     tx_q;

   // Address compare shared by the write decode and the read mux
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Build options word: the reset value with its flag bits written over it
   function automatic logic [DATA_W-1:0] build_word();
      logic [DATA_W-1:0] w;
      w                                = RST_BUILD_OPTIONS;
      w[POS_FIXED_MARKER_BIT]          = FLAG_FIXED_MARKER;
      w[POS_SECOND_PORT_MULTIPLEXER]   = FLAG_PORT_MUX;
      w[POS_FIRST_PORT_MULTIPLEXER]    = FLAG_PORT_MUX;
      w[POS_FUNCTIONAL_GATING_PRESENT] = FLAG_GATING;
      w[POS_MATRIX_TWO_OUTPUTS]        = FLAG_MATRIX_TWO_OUTPUT;
      w[POS_MATRIX_PRESENT]            = FLAG_MATRIX;
      build_word = w;
   endfunction : build_word

   // Read view of a 31-bit request bus, reserved bit 0 forced low
   function automatic logic [DATA_W-1:0] req_view(input logic [REQ_W-1:0] r);
      req_view = {r, 1'h0};
   endfunction : req_view

   // Write decode for the override registers kept in the leaf module
   assign rx_wr = bus.wr & hit(bus.addr, OFS_RECEIVE_REQ_OVERRIDE);
   assign tx_wr = bus.wr & hit(bus.addr, OFS_TRANSMIT_REQ_OVERRIDE);

   // Receive request override register
   dgc_req_override u_rx_ovr (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wr_en   (rx_wr),
      .wdata   (bus.wdata),
      .req     (rx_q)
   );

   // Transmit request override register
   dgc_req_override u_tx_ovr (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wr_en   (tx_wr),
      .wdata   (bus.wdata),
      .req     (tx_q)
   );

   // Idle tracking of channels and bus transactions
   dgc_quiesce_track u_idle (
      .sys_clk         (sys_clk),
      .rst_n           (rst_n),
      .ch_active       (ch_active),
      .bus_outstanding (bus_outstanding),
      .idle            (idle_q)
   );

   // Next state: mode register, launch pulse and the read answer
   always_comb begin
      next_st         = st;
      // Launch is a pulse; it falls back to zero unless written this cycle
      next_st.launch  = '0;
      next_st.rd_data = '0;
      if (bus.wr) begin
         if (hit(bus.addr, OFS_OPERATING_MODE_SELECT)) begin
            next_st.joint = bus.wdata[POS_MODE_JOINT];
         end
         if (hit(bus.addr, OFS_MULTI_CHANNEL_LAUNCH)) begin
            // All selected lanes leave on the same edge, zeros are no-ops
            next_st.launch = bus.wdata[NUM_CH-1:0];
         end
      end
      // Unmapped addresses and the write-only launch register read zero
      if (bus.rd) begin
         if (hit(bus.addr, OFS_OPERATING_MODE_SELECT)) begin
            next_st.rd_data[POS_MODE_JOINT] = st.joint;
         end else if (hit(bus.addr, OFS_MULTI_CHANNEL_LAUNCH)) begin
            next_st.rd_data = '0;
         end else if (hit(bus.addr, OFS_RECEIVE_REQ_OVERRIDE)) begin
            next_st.rd_data = req_view(rx_q);
         end else if (hit(bus.addr, OFS_TRANSMIT_REQ_OVERRIDE)) begin
            next_st.rd_data = req_view(tx_q);
         end else if (hit(bus.addr, OFS_ENGINE_QUIESCENT)) begin
            next_st.rd_data[POS_QUIESCENT] = idle_q;
         end else if (hit(bus.addr, OFS_BUILD_OPTIONS)) begin
            next_st.rd_data = build_word();
         end else begin
            next_st.rd_data = '0;
         end
      end
   end

   // State register; writes to read-only addresses simply fall through
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st.joint   <= RST_OPERATING_MODE;
         st.launch  <= RST_LAUNCH;
         st.rd_data <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from flip-flops of this module or its leaves
   assign rd_data         = st.rd_data;
   // One driver for the whole carrier, both fields straight from flip-flops
   assign chan_ctl        = '{joint: st.joint, launch: st.launch};
   assign rx_req          = rx_q;
   assign tx_req          = tx_q;
   assign core_idle       = idle_q;

endmodule : dgc_global_ctrl
`default_nettype wire

// >>> dgc_checker.sv
// Port checker of the DMA core global control block.
// Assumes one clock and a strobe register port that never stalls.
`timescale 1ns/1ps
`default_nettype none
module dgc_checker (
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   input wire dgc_pkg::dgc_bus_req_s  bus,
   input wire logic [31:0]            rd_data,
   input wire logic [3:0]             ch_active,
   input wire logic                   bus_outstanding,
   input wire dgc_pkg::dgc_chan_ctl_s chan_ctl,
   input wire logic [30:0]            rx_req,
   input wire logic [30:0]            tx_req,
   input wire logic                   core_idle
);
   import dgc_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Decoded accesses
   wire logic w_go = bus.wr && bus.addr == 32'h4000_2848;
   wire logic w_md = bus.wr && bus.addr == 32'h4000_2830;
   wire logic w_rx = bus.wr && bus.addr == 32'h4000_2850;
   wire logic w_tx = bus.wr && bus.addr == 32'h4000_2854;
   launch_go_a: assert property (w_go |=> chan_ctl.launch == $past(bus.wdata[3:0]))
      else $error("launch differs from write");
   launch_quiet_a: assert property (!w_go |=> chan_ctl.launch == 4'h0)
      else $error("launch without write");
   mode_set_a: assert property (w_md |=> chan_ctl.joint == $past(bus.wdata[0]))
      else $error("mode differs from write");
   rx_drive_a: assert property (w_rx |=> rx_req == $past(bus.wdata[31:1]))
      else $error("rx request differs");
   tx_drive_a: assert property (w_tx |=> tx_req == $past(bus.wdata[31:1]))
      else $error("tx request differs");
   rx_hold_a: assert property (!w_rx |=> $stable(rx_req))
      else $error("rx request moved");
   tx_hold_a: assert property (!w_tx |=> $stable(tx_req))
      else $error("tx request moved");
   idle_follow_a: assert property ($past(rst_n) |->
      core_idle == (~|$past(ch_active) & ~$past(bus_outstanding)))
      else $error("idle level wrong");
   reset_state_a: assert property ($rose(rst_n) |->
      core_idle && rx_req == 31'h0 && tx_req == 31'h0 && !chan_ctl.joint)
      else $error("reset state wrong");
   build_read_a: assert property (bus.rd && bus.addr == 32'h4000_28e0
      |=> rd_data == 32'h8000_0001)
      else $error("build word wrong");
   launch_read_a: assert property (bus.rd && bus.addr == 32'h4000_2848 |=> rd_data == 32'h0)
      else $error("launch reads nonzero");
endmodule : dgc_checker
bind dgc_global_ctrl dgc_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
   .rd_data(rd_data), .ch_active(ch_active), .bus_outstanding(bus_outstanding),
   .chan_ctl(chan_ctl), .rx_req(rx_req), .tx_req(tx_req), .core_idle(core_idle));
`default_nettype wire

// >>> dgc_peer_model.sv
// Stand-in for channel engines and bus side.
// Assumes the bench says when channels stop and when bus traffic is pending.
`timescale 1ns/1ps
`default_nettype none
module dgc_peer_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] launch,
   input  wire logic       stop,
   input  wire logic       bus_busy,
   output var  logic [3:0] ch_active,
   output var  logic       bus_outstanding
);
   // A launched lane stays busy until stopped; stop wins a same-cycle launch
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ch_active       <= 4'h0;
         bus_outstanding <= 1'h0;
      end else begin
         ch_active       <= (ch_active | launch) & ~{4{stop}};
         bus_outstanding <= bus_busy;
      end
   end
endmodule : dgc_peer_model
`default_nettype wire

// >>> dgc_global_ctrl_test.sv
// Self-checking bench of the DMA core global control block.
// Assumes reads answer one cycle later and the port never stalls.
`timescale 1ns/1ps
`default_nettype none
module dgc_global_ctrl_test;
   import dgc_pkg::*;
   logic          sys_clk   = 1'b0;
   logic          rst_n     = 1'b0;
   dgc_bus_req_s  bus       = '0;
   logic          stop      = 1'b1;
   logic          bus_busy  = 1'b0;
   logic [31:0]   rd_data;
   logic [3:0]    ch_active;
   logic          bus_outstanding;
   dgc_chan_ctl_s chan_ctl;
   dgc_chan_ctl_s ctl_seen;
   logic [30:0]   rx_req;
   logic [30:0]   tx_req;
   logic          core_idle;
   int            err_count = 0;
   int            tests_run = 0;
   int            seed      = 746;
   logic [31:0]   d;
   always #20 sys_clk = ~sys_clk;
   dgc_global_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
      .ch_active(ch_active), .bus_outstanding(bus_outstanding), .chan_ctl(chan_ctl),
      .rx_req(rx_req), .tx_req(tx_req), .core_idle(core_idle));
   dgc_peer_model peer_u (.sys_clk(sys_clk), .rst_n(rst_n), .launch(chan_ctl.launch),
      .stop(stop), .bus_busy(bus_busy), .ch_active(ch_active),
      .bus_outstanding(bus_outstanding));
   // Bit 0 of an override never reads back
   function automatic logic [31:0] req_view(input logic [31:0] v);
      return v & 32'hffff_fffe;
   endfunction : req_view
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Strobe lasts one cycle; controls are captured once they have landed
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      ctl_seen = chan_ctl;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
      @(posedge sys_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      chk(what, exp, rd_data);
   endtask : rd
   // Sets the peer, launches, lets two stages settle, then reads idle
   task automatic idle_case(input logic s, input logic b, input logic [31:0] l, input logic e);
      @(posedge sys_clk);
      stop <= s;
      bus_busy <= b;
      wr(OFS_MULTI_CHANNEL_LAUNCH, l);
      repeat (2) @(posedge sys_clk);
      rd(OFS_ENGINE_QUIESCENT, {31'h0, e}, "idle");
      chk("core_idle", {31'h0, e}, {31'h0, core_idle});
   endtask : idle_case
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // Watchdog far beyond the few hundred cycles needed
   initial begin
      #400000;
      err_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(OFS_RECEIVE_REQ_OVERRIDE, 32'h0, "rx reset");
      rd(OFS_TRANSMIT_REQ_OVERRIDE, 32'h0, "tx reset");
      rd(OFS_OPERATING_MODE_SELECT, 32'h0, "mode reset");
      rd(OFS_ENGINE_QUIESCENT, 32'h1, "idle reset");
      rd(32'h4000_2a00, 32'h0, "unmapped");
      // All ones and all zeros first, then random words
      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
         stop <= d[4];
         bus_busy <= d[5];
         wr(OFS_OPERATING_MODE_SELECT, d);
         chk("joint", {31'h0, d[0]}, {31'h0, ctl_seen.joint});
         rd(OFS_OPERATING_MODE_SELECT, {31'h0, d[0]}, "mode read");
         wr(OFS_MULTI_CHANNEL_LAUNCH, d);
         chk("launch", {28'h0, d[3:0]}, {28'h0, ctl_seen.launch});
         wr(OFS_RECEIVE_REQ_OVERRIDE, d);
         wr(OFS_TRANSMIT_REQ_OVERRIDE, ~d);
         chk("rx_req", req_view(d), {rx_req, 1'b0});
         chk("tx_req", req_view(~d), {tx_req, 1'b0});
         rd(OFS_RECEIVE_REQ_OVERRIDE, req_view(d), "rx read");
         rd(OFS_TRANSMIT_REQ_OVERRIDE, req_view(~d), "tx read");
         rd(OFS_MULTI_CHANNEL_LAUNCH, 32'h0, "launch read");
         wr(OFS_BUILD_OPTIONS, d);
         wr(OFS_ENGINE_QUIESCENT, 32'h0);
         rd(OFS_BUILD_OPTIONS, 32'h8000_0001, "build");
      end
      idle_case(1'b1, 1'b0, 32'h0, 1'b1);
      idle_case(1'b0, 1'b0, 32'h4, 1'b0);
      idle_case(1'b1, 1'b1, 32'h0, 1'b0);
      idle_case(1'b1, 1'b0, 32'h0, 1'b1);
      // Reset in mid-run clears the overrides again
      wr(OFS_TRANSMIT_REQ_OVERRIDE, 32'hffff_ffff);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chk("tx after reset", 32'h0, {1'b0, tx_req});
      rd(OFS_TRANSMIT_REQ_OVERRIDE, 32'h0, "tx read after reset");
      rd(OFS_ENGINE_QUIESCENT, 32'h1, "idle after reset");
      close_out();
   end
endmodule : dgc_global_ctrl_test
`default_nettype wire
